// file: hdl/watchdog_interval_timer.sv
// Watchdog and interval timer with protected registers and reset pin.
`default_nettype none
// Notes on behaviour
// R01: Pin reset or read-then-zero clears reset flag.
// R02: Watchdog overflow sets flag and resets chip.
// R03: Reset drives pin only when output enabled.
// R04: Low six reset-register bits read as ones.
// R05: Counter/control share address; keyed word writes only.
// R06: Reset register takes word writes only.
// R07: Key A5 with zero data clears flag.
// R08: Key 5A loads data bit six into enable.
// R09: Byte reads at three separate read addresses.
// R10: Watchdog mode with enable counts and resets.
// R11: Software rewrites counter to avoid overflow.
// R12: Pin held low 132 clocks on watchdog reset.
// R13: Same vector; flag tells the reset source.
// R14: Coincidence with output on: watchdog wins, check 520.
// R15: Early pin reset acts now, clears output enable.
// R16: Coincidence with output off: pin wins, flag cleared.
// R17: Interval mode overflow raises interrupt and flag.
// R18: Standby refused while timer enabled.
// R19: Wake counts; wrap restores clocks, starts handler.
// R20: Counter write beats same-cycle increment.
// R21: Stop timer before changing clock select.
// R22: Disabling the timer zeroes and stops counter.
// R23: Clock select picks one of eight divisions.
module watchdog_interval_timer (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire wdt_pkg::bus_req_t bus_req,
    output var  logic [7:0]        bus_rdata,
    output var  logic              bus_rvalid,
    input  wire logic              res_pin_in,
    output var  logic              res_pin_out,
    output var  logic              res_pin_oe_n,
    input  wire logic              standby_req,
    input  wire logic              nmi_wake,
    output var  logic              chip_reset,
    output var  logic              interval_irq,
    output var  logic              standby_active,
    output var  logic              standby_refused,
    output var  logic              clocks_on,
    output var  logic              nmi_start
);
    import wdt_pkg::*;

    function automatic logic wr_word(input bus_req_t r,
                                     input logic [15:0] a);
        wr_word = r.wr && r.word && (r.addr == a);
    endfunction

    mode_state_t      state_q;
    mode_state_t      state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0]       count_q;
    logic [7:0]       count_d;
    logic             ovf_q;
    logic             ovf_d;
    logic             wt_q;
    logic             wt_d;
    logic             tme_q;
    logic             tme_d;
    logic [2:0]       cks_q;
    logic [2:0]       cks_d;
    logic             watchdog_reset_flag_q;
    logic             watchdog_reset_flag_d;
    logic             reset_output_enable_q;
    logic             reset_output_enable_d;
    logic             ovf_seen_q;
    logic             ovf_seen_d;
    logic             watchdog_reset_flag_seen_q;
    logic             watchdog_reset_flag_seen_d;
    logic             pin_s1_q;
    logic             pin_s2_q;
    logic [7:0]       rdata_d;
    logic             rvalid_d;
    logic             oe_n_d;
    logic             chip_reset_d;
    logic             irq_d;
    logic             standby_d;
    logic             refused_d;
    logic             clocks_on_d;
    logic             nmi_start_d;

    logic             tick;
    logic             pin_low;
    logic             counting;
    logic             wr_open;
    logic             count_wr;
    logic             timer_control_status_wr;
    logic             watchdog_reset_flag_clr;
    logic             oe_wr;
    logic             wrap;
    logic             wdt_ovf;
    logic             ext_rst;
    logic [7:0]       key;
    logic [7:0]       dat;

    assign pin_low  = !pin_s2_q;
    assign counting = tme_q || (state_q == ST_WAKE);
    assign key      = bus_req.wdata[15:8];
    assign dat      = bus_req.wdata[7:0];
    assign wr_open  = (state_q == ST_RUN);
    assign count_wr = wr_open && wr_word(bus_req, ADDR_CTRL_WR)
                      && (key == KEY_COUNT);                      // [R05]
    assign timer_control_status_wr  = wr_open && wr_word(bus_req, ADDR_CTRL_WR)
                      && (key == KEY_CTRL);                       // [R05]
    assign watchdog_reset_flag_clr = wr_open && wr_word(bus_req, ADDR_RSTC_WR)
                      && (key == KEY_RSTC_CLR) && (dat == CLR_DATA)
                      && watchdog_reset_flag_seen_q;                       // [R06] [R07]
    assign oe_wr    = wr_open && wr_word(bus_req, ADDR_RSTC_WR)
                      && (key == KEY_RSTC_OE);                    // [R06]
    assign wrap     = tick && counting && (count_q == COUNT_MAX)
                      && !count_wr;
    assign wdt_ovf  = wrap && wt_q && tme_q && (state_q == ST_RUN); // [R10]
    assign ext_rst  = pin_low && (state_q != ST_WDT_RESET);     // [R15]

    wdt_prescaler #(
        .W (PRE_W)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .run     (counting),
        .sel     (cks_q),
        .tick    (tick)
    );

    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        count_d      = count_q;
        ovf_d        = ovf_q;
        wt_d         = wt_q;
        tme_d        = tme_q;
        cks_d        = cks_q;
        watchdog_reset_flag_d       = watchdog_reset_flag_q;
        reset_output_enable_d      = reset_output_enable_q;
        rdata_d      = bus_rdata;
        rvalid_d     = 1'b0;
        oe_n_d       = res_pin_oe_n;
        chip_reset_d = chip_reset;
        irq_d        = 1'b0;
        standby_d    = standby_active;
        refused_d    = 1'b0;
        clocks_on_d  = clocks_on;
        nmi_start_d  = 1'b0;

        if (count_wr) begin
            count_d = dat;                                        // [R20]
        end else if (tick && counting) begin
            count_d = count_q + COUNT_ONE;
        end
        if (!counting) begin
            count_d = COUNT_RESET;                                // [R22]
        end
        if (timer_control_status_wr) begin
            wt_d  = dat[CTRL_MODE_BIT];
            tme_d = dat[CTRL_RUN_BIT];
            cks_d = dat[2:0];
            if (!dat[CTRL_OVF_BIT] && ovf_seen_q) begin
                ovf_d = 1'b0;
            end
        end
        if (wrap && !wt_q && tme_q) begin
            ovf_d = 1'b1;                                         // [R17]
            irq_d = 1'b1;                                         // [R17]
        end
        if (oe_wr) begin
            reset_output_enable_d = dat[RSTC_OE_BIT];                           // [R08]
        end
        if (watchdog_reset_flag_clr) begin
            watchdog_reset_flag_d = 1'b0;                                        // [R01]
        end
        if (bus_req.rd) begin
            rvalid_d = 1'b1;                                      // [R09]
            unique case (bus_req.addr)
                ADDR_CTRL_RD:  rdata_d = {ovf_q, wt_q, tme_q, CTRL_RSV, cks_q};
                ADDR_COUNT_RD: rdata_d = count_q;
                ADDR_RSTC_RD:  rdata_d = {watchdog_reset_flag_q, reset_output_enable_q, RSTC_RSV}; // [R04]
                default:       rdata_d = RDATA_NONE;
            endcase
        end

        unique case (state_q)
            ST_RUN: begin
                if (standby_req) begin
                    if (tme_q) begin
                        refused_d = 1'b1;                         // [R18]
                    end else begin
                        state_d     = ST_STANDBY;
                        standby_d   = 1'b1;
                        clocks_on_d = 1'b0;
                        ovf_d       = 1'b0;
                        wt_d        = 1'b0;
                    end
                end
            end
            ST_WDT_RESET: begin
                cnt_d        = cnt_q + CNT_ONE;
                chip_reset_d = (cnt_d < RST_PULSE_CYC);           // [R12]
                oe_n_d       = !(chip_reset_d && reset_output_enable_q);        // [R03]
                if (cnt_q == EXT_CHECK_CYC - CNT_ONE) begin
                    state_d = ST_RUN;
                    if (pin_low) begin
                        watchdog_reset_flag_d  = 1'b0;                           // [R14]
                        reset_output_enable_d = 1'b0;                           // [R14]
                    end
                end
            end
            ST_STANDBY: begin
                if (nmi_wake) begin
                    state_d = ST_WAKE;                            // [R19]
                end
            end
            ST_WAKE: begin
                if (wrap) begin
                    state_d     = ST_RUN;                         // [R19]
                    standby_d   = 1'b0;
                    clocks_on_d = 1'b1;
                    nmi_start_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase

        if (wdt_ovf && (reset_output_enable_q || !pin_low)) begin
            watchdog_reset_flag_d       = 1'b1;                        // [R02] [R13] [R14]
            chip_reset_d = 1'b1;                                  // [R02]
            oe_n_d       = !reset_output_enable_q;                              // [R03]
            state_d      = ST_WDT_RESET;
            cnt_d        = '0;
            count_d      = COUNT_RESET;
            ovf_d        = 1'b0;
            wt_d         = 1'b0;
            tme_d        = 1'b0;
            cks_d        = CKS_RESET;
        end else if (ext_rst) begin
            watchdog_reset_flag_d       = 1'b0;                          // [R01] [R16]
            reset_output_enable_d      = 1'b0;                                  // [R15]
            state_d      = ST_RUN;
            count_d      = COUNT_RESET;
            ovf_d        = 1'b0;
            wt_d         = 1'b0;
            tme_d        = 1'b0;
            cks_d        = CKS_RESET;
            standby_d    = 1'b0;
            clocks_on_d  = 1'b1;
            nmi_start_d  = 1'b0;
            irq_d        = 1'b0;
        end

        ovf_seen_d  = (ovf_q && bus_req.rd && bus_req.addr == ADDR_CTRL_RD)
                      || ovf_seen_q;
        watchdog_reset_flag_seen_d = (watchdog_reset_flag_q && bus_req.rd && bus_req.addr == ADDR_RSTC_RD)
                      || watchdog_reset_flag_seen_q;                             // [R01]
        if (!ovf_d) begin
            ovf_seen_d = 1'b0;
        end
        if (!watchdog_reset_flag_d) begin
            watchdog_reset_flag_seen_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q         <= ST_RUN;
            cnt_q           <= '0;
            count_q         <= COUNT_RESET;
            ovf_q           <= 1'b0;
            wt_q            <= 1'b0;
            tme_q           <= 1'b0;
            cks_q           <= CKS_RESET;
            watchdog_reset_flag_q          <= 1'b0;
            reset_output_enable_q         <= 1'b0;
            ovf_seen_q      <= 1'b0;
            watchdog_reset_flag_seen_q     <= 1'b0;
            pin_s1_q        <= 1'b1;
            pin_s2_q        <= 1'b1;
            bus_rdata       <= RDATA_NONE;
            bus_rvalid      <= 1'b0;
            res_pin_out     <= 1'b0;
            res_pin_oe_n    <= 1'b1;
            chip_reset      <= 1'b0;
            interval_irq    <= 1'b0;
            standby_active  <= 1'b0;
            standby_refused <= 1'b0;
            clocks_on       <= 1'b1;
            nmi_start       <= 1'b0;
        end else if (ce) begin
            state_q         <= state_d;
            cnt_q           <= cnt_d;
            count_q         <= count_d;
            ovf_q           <= ovf_d;
            wt_q            <= wt_d;
            tme_q           <= tme_d;
            cks_q           <= cks_d;
            watchdog_reset_flag_q          <= watchdog_reset_flag_d;
            reset_output_enable_q         <= reset_output_enable_d;
            ovf_seen_q      <= ovf_seen_d;
            watchdog_reset_flag_seen_q     <= watchdog_reset_flag_seen_d;
            pin_s1_q        <= res_pin_in;
            pin_s2_q        <= pin_s1_q;
            bus_rdata       <= rdata_d;
            bus_rvalid      <= rvalid_d;
            res_pin_out     <= 1'b0;
            res_pin_oe_n    <= oe_n_d;
            chip_reset      <= chip_reset_d;
            interval_irq    <= irq_d;
            standby_active  <= standby_d;
            standby_refused <= refused_d;
            clocks_on       <= clocks_on_d;
            nmi_start       <= nmi_start_d;
        end
    end

    // Length of the current low drive on the reset pin, for checking.
    logic [CNT_W-1:0] drv_cnt_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drv_cnt_q <= '0;
        end else if (res_pin_oe_n) begin
            drv_cnt_q <= '0;
        end else if (ce) begin
            drv_cnt_q <= drv_cnt_q + CNT_ONE;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_wdt_entry;
        ce && wdt_ovf && (reset_output_enable_q || !pin_low);
    endsequence

    sequence s_late_check;
        ce && state_q == ST_WDT_RESET
        && cnt_q == EXT_CHECK_CYC - CNT_ONE && pin_low;
    endsequence

    sequence s_wake_wrap;
        ce && state_q == ST_WAKE && wrap && !ext_rst;
    endsequence

    a_pin_pulse_len: assert property ( // [R12]
        $rose(res_pin_oe_n) |-> drv_cnt_q == RST_PULSE_CYC)
        else $error("Reset pin low pulse has wrong length.");

    a_wdt_sets_flag: assert property ( // [R02]
        s_wdt_entry |=> watchdog_reset_flag_q && chip_reset && state_q == ST_WDT_RESET)
        else $error("Watchdog overflow did not set flag and reset.");

    a_pin_needs_oe: assert property ( // [R03]
        s_wdt_entry |=> (res_pin_oe_n == !$past(reset_output_enable_q)))
        else $error("Reset pin drive does not follow output enable.");

    a_late_pin_reset: assert property ( // [R14]
        s_late_check |=> !watchdog_reset_flag_q && !reset_output_enable_q && state_q == ST_RUN)
        else $error("Held pin reset did not clear both bits.");

    a_pin_wins_oe0: assert property ( // [R16]
        ce && ext_rst && !reset_output_enable_q |=> !watchdog_reset_flag_q && !chip_reset)
        else $error("Pin reset did not win with output disabled.");

    a_irq_with_flag: assert property ( // [R17]
        interval_irq |-> ovf_q && !$past(wt_q))
        else $error("Interval request without overflow flag.");

    a_reserved_ones: assert property ( // [R04]
        bus_rvalid && $past(ce) && $past(bus_req.addr) == ADDR_RSTC_RD
        |-> bus_rdata[5:0] == RSTC_RSV)
        else $error("Reserved reset register bits not read as ones.");

    a_oe_word_load: assert property ( // [R08]
        ce && oe_wr && !ext_rst && !wdt_ovf
        |=> reset_output_enable_q == $past(bus_req.wdata[RSTC_OE_BIT]))
        else $error("Keyed write did not load output enable.");

    a_write_beats_tick: assert property ( // [R20]
        ce && count_wr && tick && tme_q && !ext_rst
        |=> count_q == $past(bus_req.wdata[7:0]))
        else $error("Counter write lost against increment.");

    a_stop_clears: assert property ( // [R22]
        ce && !tme_q && state_q == ST_RUN |=> count_q == COUNT_RESET)
        else $error("Stopped counter is not zero.");

    a_standby_refused: assert property ( // [R18]
        ce && state_q == ST_RUN && standby_req && tme_q && !ext_rst
        && !wdt_ovf |=> standby_refused && !standby_active)
        else $error("Standby entered while timer enabled.");

    a_wake_exit: assert property ( // [R19]
        s_wake_wrap |=> nmi_start && clocks_on && !standby_active)
        else $error("Wake overflow did not end standby.");

endmodule
`default_nettype wire

// file: hdl/wdt_pkg.sv
// Shared constants, carriers and types of the watchdog and interval timer.
`default_nettype none
package wdt_pkg;

    localparam logic [15:0] ADDR_CTRL_WR  = 16'hFEEC;
    localparam logic [15:0] ADDR_CTRL_RD  = 16'hFEEC;
    localparam logic [15:0] ADDR_COUNT_RD = 16'hFEED;
    localparam logic [15:0] ADDR_RSTC_WR  = 16'hFF14;
    localparam logic [15:0] ADDR_RSTC_RD  = 16'hFF15;

    localparam logic [7:0]  KEY_COUNT     = 8'h5A;
    localparam logic [7:0]  KEY_CTRL      = 8'hA5;
    localparam logic [7:0]  KEY_RSTC_CLR  = 8'hA5;
    localparam logic [7:0]  KEY_RSTC_OE   = 8'h5A;
    localparam logic [7:0]  CLR_DATA      = 8'h00;

    localparam int          CTRL_OVF_BIT  = 7;
    localparam int          CTRL_MODE_BIT = 6;
    localparam int          CTRL_RUN_BIT  = 5;
    localparam int          RSTC_FLAG_BIT = 7;
    localparam int          RSTC_OE_BIT   = 6;
    localparam logic [1:0]  CTRL_RSV      = 2'h3;
    localparam logic [5:0]  RSTC_RSV      = 6'h3F;

    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [7:0]  COUNT_MAX     = 8'hFF;
    localparam logic [7:0]  COUNT_ONE     = 8'h01;
    localparam logic [2:0]  CKS_RESET     = 3'h0;
    localparam logic [7:0]  RDATA_NONE    = 8'h00;

    localparam int          CNT_W         = 10;
    localparam logic [9:0]  RST_PULSE_CYC = 10'h084;
    localparam logic [9:0]  EXT_CHECK_CYC = 10'h208;
    localparam logic [9:0]  CNT_ONE       = 10'h001;

    localparam int          PRE_W         = 12;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic        word;
        logic [15:0] wdata;
    } bus_req_t;

    typedef enum logic [3:0] {
        ST_RUN       = 4'h1,
        ST_WDT_RESET = 4'h2,
        ST_STANDBY   = 4'h4,
        ST_WAKE      = 4'h8
    } mode_state_t;

    // Mask of low prescaler bits; all ones marks the end of one division.
    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_mask = 12'h001;
            3'h1: div_mask = 12'h01F;
            3'h2: div_mask = 12'h03F;
            3'h3: div_mask = 12'h07F;
            3'h4: div_mask = 12'h0FF;
            3'h5: div_mask = 12'h1FF;
            3'h6: div_mask = 12'h7FF;
            3'h7: div_mask = 12'hFFF;
        endcase
    endfunction

endpackage
`default_nettype wire

// file: hdl/wdt_prescaler.sv
// Prescaler that makes the counter clock pulse from the system clock.
`default_nettype none
module wdt_prescaler #(
    parameter int W = wdt_pkg::PRE_W
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output var  logic       tick
);
    import wdt_pkg::*;

    logic [W-1:0] pre_q;
    logic [W-1:0] pre_d;
    logic         tick_d;

    // One pulse every selected division; stopped and cleared when idle.
    always_comb begin
        pre_d  = run ? W'(pre_q + W'(1)) : '0;
        tick_d = run && ((pre_q & W'(div_mask(sel))) == W'(div_mask(sel))); // [R23]
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
            tick  <= 1'b0;
        end else if (ce) begin
            pre_q <= pre_d;
            tick  <= tick_d;
        end
    end

endmodule
`default_nettype wire

// file: verif/reset_line_model.sv
// Open-drain reset line with a pull-up and one outside device on it.
`default_nettype none
module reset_line_model (
    input  wire logic res_pin_out,
    input  wire logic res_pin_oe_n,
    input  wire logic pull_low,
    output var  logic res_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // The pull-up holds the line high unless a party pulls it low.
    always_comb begin
        res_line = 1'b1;
        if (!res_pin_oe_n && !res_pin_out) begin
            res_line = 1'b0;
        end
        if (pull_low) begin
            res_line = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the watchdog and interval timer.
`default_nettype none
module tb_top;
    import wdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    bus_req_t   bus_req = '0;
    logic [7:0] bus_rdata;
    logic       bus_rvalid;
    logic       res_line;
    logic       res_pin_out;
    logic       res_pin_oe_n;
    logic       pull_low = 1'b0;
    logic       ce = 1'b1;
    logic       standby_req = 1'b0;
    logic       nmi_wake = 1'b0;
    logic       chip_reset;
    logic       interval_irq;
    logic       standby_active;
    logic       standby_refused;
    logic       clocks_on;
    logic       nmi_start;
    int         failures = 0;
    int         checks = 0;

    always #5 clk_sys = ~clk_sys;

    watchdog_interval_timer i_watchdog_interval_timer (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
        .res_pin_in(res_line), .res_pin_out(res_pin_out),
        .res_pin_oe_n(res_pin_oe_n), .standby_req(standby_req),
        .nmi_wake(nmi_wake), .chip_reset(chip_reset),
        .interval_irq(interval_irq), .standby_active(standby_active),
        .standby_refused(standby_refused), .clocks_on(clocks_on),
        .nmi_start(nmi_start)
    );

    reset_line_model i_reset_line_model (
        .res_pin_out(res_pin_out), .res_pin_oe_n(res_pin_oe_n),
        .pull_low(pull_low), .res_line(res_line)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic w);
        @(negedge clk_sys);
        bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, word: w, wdata: d};
        @(negedge clk_sys);
        bus_req = '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        bus_req = '{addr: a, wr: 1'b0, rd: 1'b1, word: 1'b0,
                    wdata: 16'h0000};
        @(negedge clk_sys);
        bus_req = '0;
        chk({7'h00, bus_rvalid, bus_rdata}, {8'h01, e});
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = interval_irq;
            1: pick = chip_reset;
            default: pick = nmi_start;
        endcase
    endfunction

    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        while (pick(s) !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                chk(16'h0000, 16'h0001);
                final_report();
            end
        end
    endtask

    task automatic wdog(input logic oe, input logic hold);
        int hi;
        int drv;
        hi = 0;
        drv = 0;
        wr(ADDR_CTRL_WR, 16'hA560, 1'b1);
        wr(ADDR_CTRL_WR, 16'h5AFF, 1'b1);
        wait_hi(1, 20);
        pull_low = hold;
        while (chip_reset === 1'b1 && hi < 600) begin
            hi++;
            drv += (res_pin_oe_n === 1'b0 && res_line === 1'b0);
            @(negedge clk_sys);
        end
        chk(16'(hi), 16'h0084);
        chk(16'(drv), oe ? 16'h0084 : 16'h0000);
        repeat (400) @(negedge clk_sys);
        rd(ADDR_RSTC_RD, hold ? 8'h3F : {1'b1, oe, 6'h3F});
        pull_low = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        rd(ADDR_CTRL_RD, 8'h18);
        rd(ADDR_COUNT_RD, 8'h00);
        rd(ADDR_RSTC_RD, 8'h3F);
        rd(16'h1234, RDATA_NONE);
        end_test("reset values");
        wr(ADDR_CTRL_WR, 16'hA520, 1'b0);
        wr(ADDR_RSTC_WR, 16'h5A40, 1'b0);
        wr(ADDR_CTRL_WR, 16'h3C20, 1'b1);
        rd(ADDR_CTRL_RD, 8'h18);
        rd(ADDR_RSTC_RD, 8'h3F);
        end_test("write protection");
        wr(ADDR_CTRL_WR, 16'hA520, 1'b1);
        wr(ADDR_CTRL_WR, 16'h5AF0, 1'b1);
        wait_hi(0, 40);
        rd(ADDR_CTRL_RD, 8'hB8);
        @(negedge clk_sys);
        standby_req = 1'b1;
        @(negedge clk_sys);
        standby_req = 1'b0;
        chk(16'({standby_refused, standby_active}), 16'h0002);
        wr(ADDR_CTRL_WR, 16'hA520, 1'b1);
        rd(ADDR_CTRL_RD, 8'h38);
        wr(ADDR_CTRL_WR, 16'hA500, 1'b1);
        rd(ADDR_COUNT_RD, 8'h00);
        end_test("interval mode");
        wdog(1'b0, 1'b0);
        wr(ADDR_RSTC_WR, 16'hA501, 1'b1);
        rd(ADDR_RSTC_RD, 8'hBF);
        wr(ADDR_RSTC_WR, 16'hA500, 1'b1);
        rd(ADDR_RSTC_RD, 8'h3F);
        end_test("watchdog internal");
        wr(ADDR_RSTC_WR, 16'h5A40, 1'b1);
        rd(ADDR_RSTC_RD, 8'h7F);
        wdog(1'b1, 1'b0);
        pull_low = 1'b1;
        repeat (4) @(negedge clk_sys);
        pull_low = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(ADDR_RSTC_RD, 8'h3F);
        wr(ADDR_RSTC_WR, 16'h5A40, 1'b1);
        wdog(1'b1, 1'b1);
        ce = 1'b0;
        wr(ADDR_RSTC_WR, 16'h5A40, 1'b1);
        ce = 1'b1;
        rd(ADDR_RSTC_RD, 8'h3F);
        end_test("watchdog pin");
        @(negedge clk_sys);
        standby_req = 1'b1;
        @(negedge clk_sys);
        standby_req = 1'b0;
        chk(16'({standby_active, clocks_on}), 16'h0002);
        nmi_wake = 1'b1;
        @(negedge clk_sys);
        nmi_wake = 1'b0;
        wait_hi(2, 700);
        chk(16'({standby_active, clocks_on}), 16'h0001);
        end_test("standby wake");
        final_report();
    end
endmodule
`default_nettype wire
